// ===== inc/irc_consts.vh
// constants for the remote command core
`ifndef IRC_CONSTS_VH
`define IRC_CONSTS_VH
// command opcodes
`define IRC_OP_NOP       5'h00
`define IRC_OP_FORMULA   5'h01
`define IRC_OP_MARKER    5'h02
`define IRC_OP_RATE      5'h03
`define IRC_OP_SWBEGIN   5'h04
`define IRC_OP_SWEND     5'h05
`define IRC_OP_SWINC     5'h06
`define IRC_OP_BUSPAR    5'h07
`define IRC_OP_HALT      5'h08
`define IRC_OP_REFSRC    5'h09
`define IRC_OP_CURRIN    5'h0A
`define IRC_OP_VOLTCFG   5'h0B
`define IRC_OP_CURVESZ   5'h0C
`define IRC_OP_NOTCH     5'h0D
`define IRC_OP_SINGLE    5'h0E
`define IRC_OP_CONT      5'h0F
`define IRC_OP_AMPL      5'h10
`define IRC_OP_SRQMASK   5'h11
`define IRC_OP_PRIOR     5'h12
`define IRC_OP_PROGRESS  5'h13
`define IRC_OP_OVERLOAD  5'h14
`define IRC_OP_NEWCURVE  5'h15
`define IRC_OP_DEVSEL    5'h16
`define IRC_OP_CURVESEL  5'h17
// parameter limits
`define IRC_MAX_MARKER   32'h0000_7FFF
`define IRC_MAX_FREQ     32'h0EE6_B280
`define IRC_MAX_LOGSTEP  32'h0001_86A0
`define IRC_MAX_LINSTEP  32'h0098_9680
`define IRC_MAX_ADDR     32'h0000_001F
`define IRC_MAX_TERM     32'h0000_0005
`define IRC_MAX_REFSRC   32'h0000_0002
`define IRC_MAX_CURRIN   32'h0000_0002
`define IRC_MAX_NOTCH    32'h0000_0003
`define IRC_MAX_BASE     32'h0000_0001
`define IRC_MAX_SWTYPE   32'h0000_0002
`define IRC_MAX_MASK     32'h0000_00FF
`define IRC_MAX_AMPL     16'h7530
`define IRC_HALF_FS      16'h1388
`define IRC_CURVE_POINTS 32'h0000_7FFF
// sweep types
`define IRC_SW_LOG       2'h0
`define IRC_SW_LIN       2'h1
`define IRC_SW_SEEK      2'h2
// acquisition state codes
`define IRC_ACQ_IDLE     3'h0
`define IRC_ACQ_SINGLE   3'h1
`define IRC_ACQ_CONT     3'h2
`define IRC_ACQ_SHALT    3'h5
`define IRC_ACQ_CHALT    3'h6
// status byte bits
`define IRC_ST_DONE      0
`define IRC_ST_CMDERR    1
`define IRC_ST_PARERR    2
// overload byte bits
`define IRC_OV_CH1       1
`define IRC_OV_CH2       2
`define IRC_OV_Y         3
`define IRC_OV_X         4
`define IRC_OV_INPUT     6
`define IRC_OV_UNLOCK    7
// reset values
`define IRC_RST_TERM     3'h0
`define IRC_RST_CURVELEN 32'h0000_0100
`define IRC_RST_CURVESEL 21'h00_0001
`endif

// ===== hw/irc_command_core.v
// remote command interpreter for an instrument control core
`timescale 1ns/1ns
`include "irc_consts.vh"

// Function
// - formula 1 or 2 returns signed 32-bit result
// - marker tag 0..32767 stored per sample
// - external unlocked rate 0, else frequency
// - sweep begin/end accept 0..250 kHz
// - increment selects log, linear, linear seek
// - seek sweep stops above half scale
// - bus address 0..31 kept as listen address
// - terminator code picks ending and echo
// - source codes internal, rear, front input
// - nonzero current select overrides voltage config
// - curve size above limit gives parameter error
// - notch mode and base frequency decoded
// - progress state codes 0,1,2,5,6
// - sweeps counter counts completions, cleared
// - points counter counts stores, cleared
// - progress third value is prior status
// - amplitude readout clamps to 0..30000
// - service request mask 0..255 stored
// - unaddressed ignores all but device select
// - device select compares panel address
// - overload byte bit layout, unused zero
// - new curve clears storage and status
module irc_command_core (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        clkEn,
  input  wire        cmdValid,
  input  wire [4:0]  cmdOp,
  input  wire        cmdHasArg,
  input  wire [31:0] cmdArg1,
  input  wire [31:0] cmdArg2,
  input  wire [4:0]  panelAddr,
  input  wire        daisyChain,
  input  wire [31:0] formula1Val,
  input  wire [31:0] formula2Val,
  input  wire [31:0] refInFreq,
  input  wire [31:0] oscFreq,
  input  wire        refLocked,
  input  wire [15:0] magnitudeIn,
  input  wire        sampleStrobe,
  input  wire        cycleDone,
  input  wire        ovCh1,
  input  wire        ovCh2,
  input  wire        ovY,
  input  wire        ovX,
  input  wire        ovInput,
  output reg         rspValid,
  output reg  [31:0] rspVal1,
  output reg  [31:0] rspVal2,
  output reg  [31:0] rspVal3,
  output reg  [31:0] rspVal4,
  output reg  [15:0] markerOut,
  output reg         markerStore,
  output reg  [31:0] sweepBegin,
  output reg  [31:0] sweepEnd,
  output reg  [31:0] sweepStep,
  output reg  [1:0]  sweepType,
  input  wire        sweepStart,
  output reg         sweepRun,
  output reg  [4:0]  listenAddr,
  output reg  [1:0]  termSel,
  output reg         testEcho,
  output reg  [1:0]  refSource,
  output reg  [1:0]  currentSel,
  output reg  [1:0]  voltageCfg,
  output reg         currentMode,
  output reg  [31:0] curveLen,
  output reg  [20:0] curveSel,
  output reg  [1:0]  notchMode,
  output reg         notchBase50,
  output reg  [7:0]  srqMask,
  output reg         addressed,
  output reg         curveClear,
  output reg  [2:0]  acqState
);

  reg  [7:0]  status_ff;
  reg  [31:0] sweeps_ff;
  reg  [31:0] points_ff;
  reg  [31:0] maxLen;
  reg  [4:0]  nSel;
  reg         accept;
  reg         badParam;
  reg         isQuery;
  reg  [31:0] nxt_v1;
  integer     i;

  // allowed length shrinks as more curves share the store
  function [31:0] len_limit;
    input [4:0] n;
    begin
      if (n == 5'h00)
        len_limit = `IRC_CURVE_POINTS;
      else
        len_limit = `IRC_CURVE_POINTS / {27'h0, n};
    end
  endfunction

  always @* begin
    nSel = 5'h00;
    for (i = 0; i < 21; i = i + 1) begin
      nSel = nSel + {4'h0, curveSel[i]};
    end
    maxLen = len_limit(nSel);
  end

  always @* begin
    accept = cmdValid && (!daisyChain || addressed ||
             cmdOp == `IRC_OP_DEVSEL);
  end

  always @* begin
    badParam = 1'b0;
    isQuery = !cmdHasArg;
    case (cmdOp)
      `IRC_OP_FORMULA:
        badParam = cmdArg1 != 32'h1 && cmdArg1 != 32'h2;
      `IRC_OP_MARKER:
        badParam = cmdHasArg && cmdArg1 > `IRC_MAX_MARKER;
      `IRC_OP_SWBEGIN, `IRC_OP_SWEND:
        badParam = cmdHasArg && cmdArg1 > `IRC_MAX_FREQ;
      `IRC_OP_SWINC:
        badParam = cmdHasArg && (cmdArg2 > `IRC_MAX_SWTYPE ||
          (cmdArg2 == 32'h0 ? cmdArg1 > `IRC_MAX_LOGSTEP
                            : cmdArg1 > `IRC_MAX_LINSTEP));
      `IRC_OP_BUSPAR:
        badParam = cmdHasArg && (cmdArg1 > `IRC_MAX_ADDR ||
                   cmdArg2 > `IRC_MAX_TERM);
      `IRC_OP_REFSRC:
        badParam = cmdHasArg && cmdArg1 > `IRC_MAX_REFSRC;
      `IRC_OP_CURRIN, `IRC_OP_VOLTCFG:
        badParam = cmdHasArg && cmdArg1 > `IRC_MAX_CURRIN;
      `IRC_OP_CURVESZ:
        badParam = cmdHasArg && cmdArg1 > maxLen;
      `IRC_OP_NOTCH:
        badParam = cmdHasArg && (cmdArg1 > `IRC_MAX_NOTCH ||
                   cmdArg2 > `IRC_MAX_BASE);
      `IRC_OP_SRQMASK:
        badParam = cmdHasArg && cmdArg1 > `IRC_MAX_MASK;
      `IRC_OP_CURVESEL:
        badParam = cmdHasArg && cmdArg1[31:21] != 11'h0;
      default:
        badParam = 1'b0;
    endcase
  end

  // first answer word
  always @* begin
    nxt_v1 = 32'h0;
    case (cmdOp)
      `IRC_OP_FORMULA:
        nxt_v1 = (cmdArg1 == 32'h2) ? formula2Val : formula1Val;
      `IRC_OP_MARKER:
        nxt_v1 = {16'h0, markerOut};
      `IRC_OP_RATE:
        nxt_v1 = (refSource == 2'h0) ? oscFreq :
                 (refLocked ? refInFreq : 32'h0);
      `IRC_OP_SWBEGIN:
        nxt_v1 = sweepBegin;
      `IRC_OP_SWEND:
        nxt_v1 = sweepEnd;
      `IRC_OP_SWINC:
        nxt_v1 = sweepStep;
      `IRC_OP_BUSPAR:
        nxt_v1 = {27'h0, listenAddr};
      `IRC_OP_REFSRC:
        nxt_v1 = {30'h0, refSource};
      `IRC_OP_CURRIN:
        nxt_v1 = {30'h0, currentSel};
      `IRC_OP_VOLTCFG:
        nxt_v1 = {30'h0, voltageCfg};
      `IRC_OP_CURVESZ:
        nxt_v1 = curveLen;
      `IRC_OP_CURVESEL:
        nxt_v1 = {11'h0, curveSel};
      `IRC_OP_NOTCH:
        nxt_v1 = {30'h0, notchMode};
      `IRC_OP_AMPL:
        nxt_v1 = {16'h0, (magnitudeIn > `IRC_MAX_AMPL) ?
                 `IRC_MAX_AMPL : magnitudeIn};
      `IRC_OP_SRQMASK:
        nxt_v1 = {24'h0, srqMask};
      `IRC_OP_PRIOR:
        nxt_v1 = {24'h0, status_ff};
      `IRC_OP_PROGRESS:
        nxt_v1 = {29'h0, acqState};
      `IRC_OP_OVERLOAD:
        nxt_v1 = {24'h0, !refLocked, ovInput, 1'b0, ovX, ovY,
                  ovCh2, ovCh1, 1'b0};
      default:
        nxt_v1 = 32'h0;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid    <= 1'b0;
      rspVal1     <= 32'h0;
      rspVal2     <= 32'h0;
      rspVal3     <= 32'h0;
      rspVal4     <= 32'h0;
      markerOut   <= 16'h0;
      markerStore <= 1'b0;
      sweepBegin  <= 32'h0;
      sweepEnd    <= 32'h0;
      sweepStep   <= 32'h0;
      sweepType   <= `IRC_SW_LOG;
      sweepRun    <= 1'b0;
      listenAddr  <= 5'h0;
      termSel     <= 2'h0;
      testEcho    <= 1'b0;
      refSource   <= 2'h0;
      currentSel  <= 2'h0;
      voltageCfg  <= 2'h0;
      currentMode <= 1'b0;
      curveLen    <= `IRC_RST_CURVELEN;
      curveSel    <= `IRC_RST_CURVESEL;
      notchMode   <= 2'h0;
      notchBase50 <= 1'b0;
      srqMask     <= 8'h0;
      addressed   <= 1'b1;
      curveClear  <= 1'b0;
      acqState    <= `IRC_ACQ_IDLE;
      status_ff   <= 8'h0;
      sweeps_ff   <= 32'h0;
      points_ff   <= 32'h0;
    end else if (clkEn) begin
      rspValid    <= 1'b0;
      curveClear  <= 1'b0;
      currentMode <= currentSel != 2'h0;
      // marker captured per sample when bit 13 selected
      markerStore <= sampleStrobe && curveSel[13] &&
                     (acqState == `IRC_ACQ_SINGLE ||
                      acqState == `IRC_ACQ_CONT);
      // seek stops itself above half scale
      if (sweepRun && sweepType == `IRC_SW_SEEK &&
          magnitudeIn > `IRC_HALF_FS)
        sweepRun <= 1'b0;
      else if (sweepStart)
        sweepRun <= 1'b1;
      if ((acqState == `IRC_ACQ_SINGLE ||
           acqState == `IRC_ACQ_CONT) && sampleStrobe)
        points_ff <= points_ff + 32'h1;
      if ((acqState == `IRC_ACQ_SINGLE ||
           acqState == `IRC_ACQ_CONT) && cycleDone) begin
        sweeps_ff <= sweeps_ff + 32'h1;
        if (acqState == `IRC_ACQ_SINGLE)
          acqState <= `IRC_ACQ_IDLE;
      end
      if (accept) begin
        rspValid <= 1'b1;
        rspVal1  <= nxt_v1;
        rspVal2  <= 32'h0;
        rspVal3  <= 32'h0;
        rspVal4  <= 32'h0;
        // status refers to the prior command
        if (cmdOp == `IRC_OP_PROGRESS) begin
          rspVal2 <= sweeps_ff;
          rspVal3 <= {24'h0, status_ff};
          rspVal4 <= points_ff;
        end
        // terminator code reads back as written
        if (cmdOp == `IRC_OP_BUSPAR)
          rspVal2 <= {29'h0, termSel, testEcho};
        if (cmdOp == `IRC_OP_SWINC)
          rspVal2 <= {30'h0, sweepType};
        if (cmdOp == `IRC_OP_NOTCH)
          rspVal2 <= {31'h0, notchBase50};
        // error kept in status, setting untouched
        status_ff <= {5'h0, badParam,
                      cmdOp > `IRC_OP_CURVESEL, 1'b1};
        if (!badParam && cmdOp <= `IRC_OP_CURVESEL) begin
          case (cmdOp)
            `IRC_OP_MARKER:
              if (!isQuery) markerOut <= cmdArg1[15:0];
            `IRC_OP_SWBEGIN:
              if (!isQuery) sweepBegin <= cmdArg1;
            `IRC_OP_SWEND:
              if (!isQuery) sweepEnd <= cmdArg1;
            `IRC_OP_SWINC:
              if (!isQuery) begin
                sweepStep <= cmdArg1;
                sweepType <= cmdArg2[1:0];
              end
            `IRC_OP_BUSPAR:
              if (!isQuery) begin
                listenAddr <= cmdArg1[4:0];
                termSel    <= cmdArg2[2:1];
                testEcho   <= cmdArg2[0];
              end
            `IRC_OP_HALT:
              if (acqState == `IRC_ACQ_SINGLE)
                acqState <= `IRC_ACQ_SHALT;
              else if (acqState == `IRC_ACQ_CONT)
                acqState <= `IRC_ACQ_CHALT;
            `IRC_OP_REFSRC:
              if (!isQuery) refSource <= cmdArg1[1:0];
            `IRC_OP_CURRIN:
              if (!isQuery) currentSel <= cmdArg1[1:0];
            `IRC_OP_VOLTCFG:
              if (!isQuery) voltageCfg <= cmdArg1[1:0];
            `IRC_OP_CURVESZ:
              if (!isQuery) curveLen <= cmdArg1;
              else begin
                sweeps_ff <= 32'h0;
                points_ff <= 32'h0;
              end
            `IRC_OP_CURVESEL:
              if (!isQuery) curveSel <= cmdArg1[20:0];
              else begin
                sweeps_ff <= 32'h0;
                points_ff <= 32'h0;
              end
            `IRC_OP_NOTCH:
              if (!isQuery) begin
                notchMode   <= cmdArg1[1:0];
                notchBase50 <= cmdArg2[0];
              end
            `IRC_OP_SINGLE:
              acqState <= `IRC_ACQ_SINGLE;
            `IRC_OP_CONT:
              acqState <= `IRC_ACQ_CONT;
            `IRC_OP_SRQMASK:
              if (!isQuery) srqMask <= cmdArg1[7:0];
            `IRC_OP_NEWCURVE: begin
              curveClear <= 1'b1;
              acqState   <= `IRC_ACQ_IDLE;
              sweeps_ff  <= 32'h0;
              points_ff  <= 32'h0;
            end
            `IRC_OP_DEVSEL:
              addressed <= cmdArg1[4:0] == panelAddr &&
                           cmdArg1[31:5] == 27'h0;
            default:
              addressed <= addressed;
          endcase
        end
      end
    end
  end

endmodule // irc_command_core

// ===== tb/irc_command_core_sva.sv
// port assertions for the remote command core
`timescale 1ns/1ns
`include "irc_consts.vh"
module irc_command_core_sva (
  input wire        mclk, rst_n, clkEn, cmdValid, cmdHasArg, daisyChain,
  input wire        refLocked, sampleStrobe, sweepStart, ovCh1, ovCh2,
  input wire        ovY, ovX, ovInput, rspValid, markerStore, sweepRun,
  input wire        testEcho, currentMode, addressed,
  input wire [4:0]  cmdOp, panelAddr, listenAddr,
  input wire [31:0] cmdArg1, cmdArg2, rspVal1,
  input wire [15:0] magnitudeIn,
  input wire [1:0]  sweepType, termSel, currentSel,
  input wire [20:0] curveSel,
  input wire [2:0]  acqState
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // chain gating lets only the select command through while unaddressed
  wire take = clkEn && cmdValid &&
              (!daisyChain || addressed || cmdOp == `IRC_OP_DEVSEL);
  wire run = acqState == `IRC_ACQ_SINGLE || acqState == `IRC_ACQ_CONT;
  wire bus = take && cmdOp == `IRC_OP_BUSPAR && cmdHasArg &&
             cmdArg1 <= `IRC_MAX_ADDR && cmdArg2 <= `IRC_MAX_TERM;
  property p_answer;
    take |=> rspValid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_silent;
    clkEn && !take |=> !rspValid;
  endproperty
  a_silent: assert property (p_silent) else $error("stray answer");
  property p_marker;
    clkEn && sampleStrobe && curveSel[13] && run |=> markerStore;
  endproperty
  a_marker: assert property (p_marker) else $error("tag not stored");
  property p_term;
    bus |=> {30'h0, termSel} == ($past(cmdArg2) >> 1) &&
      {31'h0, testEcho} == ($past(cmdArg2) & 32'h1) &&
      {27'h0, listenAddr} == $past(cmdArg1);
  endproperty
  a_term: assert property (p_term) else $error("bus setting");
  property p_current;
    clkEn |=> currentMode == ($past(currentSel) != 2'h0);
  endproperty
  a_current: assert property (p_current) else $error("input mode");
  property p_overload;
    take && cmdOp == `IRC_OP_OVERLOAD |=> rspVal1 == {24'h0,
      !$past(refLocked), $past(ovInput), 1'b0, $past(ovX), $past(ovY),
      $past(ovCh2), $past(ovCh1), 1'b0};
  endproperty
  a_overload: assert property (p_overload) else $error("overload");
  property p_seek;
    clkEn && sweepRun && sweepType == `IRC_SW_SEEK && !sweepStart &&
      magnitudeIn > `IRC_HALF_FS |-> ##[1:2] !sweepRun;
  endproperty
  a_seek: assert property (p_seek) else $error("seek kept running");
  property p_devsel;
    take && cmdOp == `IRC_OP_DEVSEL && cmdHasArg |=>
      addressed == ($past(cmdArg1) == {27'h0, $past(panelAddr)});
  endproperty
  a_devsel: assert property (p_devsel) else $error("select");
endmodule // irc_command_core_sva
bind irc_command_core irc_command_core_sva u_irc_command_core_sva (.*);

// ===== tb/irc_front_model.sv
// front-end stand-in: sample pacing, cycle ends, magnitude, readouts
`timescale 1ns/1ns
module irc_front_model #(
  parameter [31:0] F1 = 32'h0,
  parameter [31:0] RF = 32'h0,
  parameter [31:0] OF = 32'h0
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        slow,
  input  wire        sweepRun,
  input  wire [2:0]  acqState,
  output wire        sampleStrobe,
  output wire        cycleDone,
  output wire [15:0] magnitudeIn,
  output wire [31:0] formula1Val,
  output wire [31:0] formula2Val,
  output wire [31:0] refInFreq,
  output wire [31:0] oscFreq
);
  reg  [2:0]  tick_ff;
  reg  [1:0]  pts_ff;
  reg         strobe_ff;
  reg         done_ff;
  reg  [15:0] mag_ff;
  wire        run = acqState == 3'h1 || acqState == 3'h2;
  wire        hit = run && tick_ff == (slow ? 3'h5 : 3'h1);
  assign sampleStrobe = strobe_ff;
  assign cycleDone = done_ff;
  assign magnitudeIn = mag_ff;
  assign formula1Val = F1;
  assign formula2Val = ~F1;
  assign refInFreq = RF;
  assign oscFreq = OF;
  // falling edge, so the core never samples a line while it moves
  always @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 3'h0;
      pts_ff <= 2'h0;
      strobe_ff <= 1'b0;
      done_ff <= 1'b0;
      mag_ff <= 16'h0000;
    end else begin
      // signal only climbs while the oscillator sweeps
      mag_ff <= sweepRun ? mag_ff + 16'h0064 : 16'h0000;
      tick_ff <= (run && !hit) ? tick_ff + 3'h1 : 3'h0;
      strobe_ff <= hit;
      done_ff <= hit && pts_ff == 2'h3;
      pts_ff <= pts_ff + {1'b0, hit};
    end
  end
endmodule // irc_front_model

// ===== tb/irc_command_core_tb.sv
// self-checking bench for the remote command core
`timescale 1ns/1ns
`include "irc_consts.vh"
module irc_command_core_tb;
  localparam [31:0] F1 = 32'hFFFF_FF9C;
  localparam [31:0] RF = 32'h0001_86A0;
  localparam [31:0] OF = 32'h0000_2710;
  reg         mclk, rst_n, clkEn, cmdValid, cmdHasArg, daisyChain, slow;
  reg         refLocked, sweepStart, ovCh1, ovCh2, ovY, ovX, ovInput, mute;
  reg  [4:0]  cmdOp, panelAddr;
  reg  [31:0] cmdArg1, cmdArg2, r, k;
  reg  [69:0] q[$];
  reg  [69:0] n;
  integer     badCount, checked;
  wire        rspValid, markerStore, sweepRun, testEcho, currentMode;
  wire        notchBase50, addressed, curveClear, sampleStrobe, cycleDone;
  wire [31:0] rspVal1, rspVal2, rspVal3, rspVal4, sweepBegin, sweepEnd;
  wire [31:0] sweepStep, curveLen, formula1Val, formula2Val, refInFreq;
  wire [31:0] oscFreq;
  wire [15:0] markerOut, magnitudeIn;
  wire [1:0]  sweepType, termSel, refSource, currentSel, voltageCfg;
  wire [1:0]  notchMode;
  wire [4:0]  listenAddr;
  wire [7:0]  srqMask;
  wire [20:0] curveSel;
  wire [2:0]  acqState;
  irc_command_core u_irc_command_core (.*);
  irc_front_model #(.F1(F1), .RF(RF), .OF(OF)) u_irc_front_model (.*);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      badCount = badCount + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task issue(input [4:0] op, input h, input [31:0] a1, input [31:0] a2 = 0,
             input [3:0] m = 0, input [31:0] e1 = 0, input [31:0] e2 = 0,
             input [1:0] es = 0);
    cmdOp = op;
    cmdHasArg = h;
    cmdArg1 = a1;
    cmdArg2 = a2;
    cmdValid = 1'b1;
    if (!mute) q.push_back({m, e1, e2, es});
    @(negedge mclk);
  endtask
  task gap;
    cmdValid = 1'b0;
    @(negedge mclk);
  endtask
  task completeRun;
    $display("comparisons %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // answers are matched in order against the notes of the driver
  always @(negedge mclk) begin
    if (rspValid === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        n = q.pop_front();
        if (n[66]) chk(rspVal1, n[65:34]);
        if (n[67]) chk(rspVal2, n[33:2]);
        if (n[68]) chk({30'h0, rspVal3[2:1]}, {30'h0, n[1:0]});
        // the front model stores four points per completed cycle
        if (n[69]) chk(rspVal4, {n[31:2], 2'h0});
      end
    end
  end
  initial begin
    #400000;
    badCount = badCount + 1;
    completeRun;
  end
  initial begin
    {rst_n, cmdValid, cmdHasArg, daisyChain, slow, sweepStart, mute} = 0;
    {ovCh1, ovCh2, ovY, ovX, ovInput, cmdOp, cmdArg1, cmdArg2} = 0;
    {clkEn, refLocked, panelAddr, badCount, checked} = {7'h7F, 64'h0};
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    r = $urandom(75715);
    chk(curveLen, `IRC_RST_CURVELEN);
    for (k = 0; k < 4; k = k + 1) begin
      issue(`IRC_OP_REFSRC, 1, k, 0, {3'h0, k < 3}, k ? k - 1 : 0);
      chk({30'h0, refSource}, k < 3 ? k : 2);
    end
    issue(`IRC_OP_PROGRESS, 0, 0, 0, 4'h4, 0, 0, 2'h2);
    issue(`IRC_OP_RATE, 0, 0, 0, 4'h1, RF);
    refLocked = 1'b0;
    issue(`IRC_OP_RATE, 0, 0, 0, 4'h1, 0);
    issue(`IRC_OP_REFSRC, 1, 0);
    issue(`IRC_OP_RATE, 0, 0, 0, 4'h1, OF);
    issue(`IRC_OP_FORMULA, 1, 2, 0, 4'h1, ~F1);
    for (k = 0; k < 7; k = k + 1) begin
      issue(`IRC_OP_BUSPAR, 1, 31 - k, k, 4'h3, k ? 32 - k : 0,
            k ? k - 1 : 0);
      r = (k < 6) ? k : 5;
      chk({termSel, testEcho, listenAddr},
          {r[2:1], r[0], 5'h1F - r[4:0]});
    end
    for (k = 0; k < 9; k = k + 1) begin
      issue(`IRC_OP_NOTCH, 1, k[1:0] | {k[3], 2'h0}, k[2]);
      chk({notchMode, notchBase50}, {k[1:0] | {2{k[3]}}, k[2] | k[3]});
    end
    r = $urandom % (`IRC_MAX_FREQ + 1);
    issue(`IRC_OP_SWBEGIN, 1, r);
    issue(`IRC_OP_SWEND, 1, `IRC_MAX_FREQ + 1);
    issue(`IRC_OP_SWEND, 1, `IRC_MAX_FREQ);
    chk(sweepBegin, r);
    chk(sweepEnd, `IRC_MAX_FREQ);
    for (k = 0; k < 4; k = k + 1) begin
      issue(`IRC_OP_SWINC, 1, 32'h5, k, 4'h3, k ? 5 : 0,
            k ? k - 1 : 0);
      chk({30'h0, sweepType}, k < 3 ? k : 2);
    end
    chk(sweepStep, 32'h5);
    gap;
    sweepStart = 1'b1;
    @(negedge mclk);
    sweepStart = 1'b0;
    for (k = 0; k < 200 && sweepRun === 1'b1; k = k + 1) @(negedge mclk);
    chk({31'h0, k > 45 && k < 60}, 32'h1);
    // a linear sweep never stops itself, so the magnitude passes the clamp
    issue(`IRC_OP_SWINC, 1, 32'h5, 1);
    gap;
    sweepStart = 1'b1;
    repeat (320) @(negedge mclk);
    sweepStart = 1'b0;
    issue(`IRC_OP_AMPL, 0, 0, 0, 4'h1, {16'h0, `IRC_MAX_AMPL});
    issue(`IRC_OP_SWINC, 1, 32'h5, 2);
    gap;
    chk({31'h0, sweepRun}, 32'h0);
    issue(`IRC_OP_CURRIN, 1, 2);
    gap;
    chk({31'h0, currentMode}, 32'h1);
    issue(`IRC_OP_CURRIN, 1, 0);
    gap;
    chk({31'h0, currentMode}, 32'h0);
    r = $urandom & 32'h7FFF;
    issue(`IRC_OP_MARKER, 1, r);
    issue(`IRC_OP_MARKER, 1, 32'h8000);
    chk({16'h0, markerOut}, r);
    r = $urandom & 32'hFF;
    issue(`IRC_OP_SRQMASK, 1, r);
    issue(`IRC_OP_SRQMASK, 1, 32'h100, 0, 4'h1, r);
    chk({24'h0, srqMask}, r);
    for (k = 0; k < 4; k = k + 1) begin
      r = $urandom;
      {refLocked, ovInput, ovX, ovY, ovCh2, ovCh1} = r[5:0];
      issue(`IRC_OP_OVERLOAD, 0, 0, 0, 1, {~r[5], r[4], 1'b0, r[3:0], 1'b0});
    end
    issue(`IRC_OP_CURVESEL, 1, 32'h2001);
    issue(`IRC_OP_CURVESZ, 1, 32'h4000);
    chk(curveLen, `IRC_RST_CURVELEN);
    issue(`IRC_OP_CURVESZ, 1, 32'h3FFF);
    chk(curveLen, 32'h3FFF);
    issue(`IRC_OP_CURVESZ, 1, 32'h4);
    issue(`IRC_OP_NEWCURVE, 0, 0);
    chk({31'h0, curveClear}, 32'h1);
    issue(`IRC_OP_SINGLE, 0, 0);
    chk({29'h0, acqState}, 32'h1);
    gap;
    for (k = 0; k < 99 && acqState !== 3'h0; k = k + 1) @(negedge mclk);
    issue(`IRC_OP_PROGRESS, 0, 0, 0, 4'hB, 0, 1);
    issue(`IRC_OP_CURVESEL, 0, 0);
    issue(`IRC_OP_PROGRESS, 0, 0, 0, 4'hB);
    slow = 1'b1;
    for (k = 0; k < 2; k = k + 1) begin
      issue(k ? `IRC_OP_CONT : `IRC_OP_SINGLE, 0, 0);
      issue(`IRC_OP_HALT, 0, 0);
      issue(`IRC_OP_PROGRESS, 0, 0, 0, 4'h1, 5 + k);
    end
    issue(`IRC_OP_NEWCURVE, 0, 0);
    chk({31'h0, curveClear}, 32'h1);
    issue(`IRC_OP_PROGRESS, 0, 0, 0, 4'hB);
    daisyChain = 1'b1;
    issue(`IRC_OP_DEVSEL, 1, 32'h8);
    chk({31'h0, addressed}, 32'h0);
    mute = 1'b1;
    issue(`IRC_OP_REFSRC, 1, 1);
    mute = 1'b0;
    issue(`IRC_OP_DEVSEL, 1, 32'h1F);
    chk({31'h0, addressed}, 32'h1);
    chk({30'h0, refSource}, 32'h0);
    daisyChain = 1'b0;
    issue(5'h1F, 0, 0);
    issue(`IRC_OP_PROGRESS, 0, 0, 0, 4'h4, 0, 0, 2'h1);
    gap;
    repeat (3) @(negedge mclk);
    chk(q.size(), 32'h0);
    completeRun;
  end
endmodule // irc_command_core_tb
